/* sleep_pkg.sv */
`default_nettype none

package sleep_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          APB_ADDR_W        = 8;
  localparam logic [7:0]  SLEEP_CONTROL_OFF = 8'h00;
  localparam logic [7:0]  SLEEP_STATUS_OFF  = 8'h04;
  localparam logic [2:0]  SLEEP_CONTROL_RST = 3'h0;
  localparam int          SEN_BIT           = 0;
  localparam int          MODE_LSB          = 1;
  localparam int          MODE_MSB          = 2;
  localparam int          CONTROL_W         = 3;

  // ****************************************************************
  // Sleep mode codes and fuse values
  // ****************************************************************
  localparam logic [1:0]  MODE_IDLE         = 2'h0;
  localparam logic [1:0]  MODE_STANDBY      = 2'h1;
  localparam logic [1:0]  MODE_POWER_DOWN   = 2'h2;
  localparam logic [1:0]  BOD_WAIT_CFG      = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          WAKE_CLK_CYCLES   = 6;

  // ****************************************************************
  // Standby wake sources gated by their run-in-standby setting
  // ****************************************************************
  localparam int          WK_RTC            = 0;
  localparam int          WK_CUSTOM         = 1;
  localparam int          WK_TIMER_B        = 2;
  localparam int          WK_ADC_WINDOW     = 3;
  localparam int          WK_COMPARATOR     = 4;
  localparam int          WK_UART_SOF       = 5;
  localparam int          N_SBY_WAKE        = 6;

  typedef enum logic [4:0]
  {
    ST_ACTIVE     = 5'h01,
    ST_IDLE       = 5'h02,
    ST_STANDBY    = 5'h04,
    ST_POWER_DOWN = 5'h08,
    ST_WAKING     = 5'h10
  } sleep_state_t;

endpackage

`default_nettype wire

/* wake_timer_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface wake_timer_if;
  logic start;
  logic need_osc;
  logic need_bod;
  logic osc_ready;
  logic bod_ready;
  logic done;

  modport ctrl
  (
    output start,
    output need_osc,
    output need_bod,
    output osc_ready,
    output bod_ready,
    input  done
  );

  modport timer
  (
    input  start,
    input  need_osc,
    input  need_bod,
    input  osc_ready,
    input  bod_ready,
    output done
  );
endinterface

`default_nettype wire

/* wake_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module wake_timer
  import sleep_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CLK_CYCLES,
  parameter int CNT_W       = 3
)
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control side.
  wake_timer_if.timer     tif
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(WAKE_CYCLES - 1);

  logic             busy;
  logic             next_busy;
  logic             osc_wait;
  logic             next_osc_wait;
  logic             bod_wait;
  logic             next_bod_wait;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             count_end;

  // The count only runs once the oscillator is up.
  assign count_end = busy && !osc_wait && (count == LAST);
  // A slow brown-out detector stretches the wake time.
  assign tif.done  = count_end && (!bod_wait || tif.bod_ready);

  always_comb
  begin
    next_busy     = busy;
    next_osc_wait = osc_wait;
    next_bod_wait = bod_wait;
    next_count    = count;
    if (tif.start)
    begin
      next_busy     = 1'b1;
      next_count    = '0;
      next_osc_wait = tif.need_osc;
      next_bod_wait = tif.need_bod;
    end
    else if (busy)
    begin
      if (osc_wait)
      begin
        if (tif.osc_ready)
        begin
          next_osc_wait = 1'b0;
        end
      end
      else if (tif.done)
      begin
        next_busy = 1'b0;
      end
      else if (count != LAST)
      begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy     <= 1'b0;
      osc_wait <= 1'b0;
      bod_wait <= 1'b0;
      count    <= '0;
    end
    else
    begin
      busy     <= next_busy;
      osc_wait <= next_osc_wait;
      bod_wait <= next_bod_wait;
      count    <= next_count;
    end
  end

endmodule

`default_nettype wire

/* sleep_controller.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module sleep_controller
  import sleep_pkg::*;
#(
  parameter int N_PERIPH = 8
)
(
  // Clock and reset.
  input  wire logic                  CORE_CLK,
  input  wire logic                  ARST_N,
  // APB slave.
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [APB_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // CPU side.
  input  wire logic                  SLEEP_EXEC,
  input  wire logic                  IRQ_ANY,
  input  wire logic                  DEBUG_BREAK,
  output logic                       CPU_CLK_EN,
  output logic                       WAKE_RESUME,
  // Wake sources.
  input  wire logic                  WAKE_PIN,
  input  wire logic                  WAKE_PIT,
  input  wire logic                  WAKE_VLM,
  input  wire logic                  WAKE_TWI,
  input  wire logic [N_SBY_WAKE-1:0] WAKE_SBY,
  input  wire logic [N_SBY_WAKE-1:0] SBY_RUN,
  input  wire logic                  CUSTOM_CLOCKLESS,
  // Peripheral clock gating.
  input  wire logic [N_PERIPH-1:0]   PERIPH_RUN_IN_STANDBY,
  output logic      [N_PERIPH-1:0]   PERIPH_CLK_EN,
  // Oscillators and brown-out detector.
  input  wire logic                  MAIN_OSC_RUN_IN_STANDBY,
  input  wire logic                  OSC_READY,
  input  wire logic                  ULP_REQ,
  input  wire logic                  RTC_CLK_REQ,
  input  wire logic [1:0]            BOD_ACTIVE_CFG,
  input  wire logic                  BOD_READY,
  output logic                       MAIN_OSC_EN,
  output logic                       ULP_OSC_EN,
  output logic                       RTC_CLK_EN
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // The main oscillator is stopped in Standby when nothing asks for it.
  function automatic logic main_osc_off(sleep_state_t st, logic keep);
    main_osc_off = 1'b0;
    case (st)
      ST_STANDBY:    main_osc_off = !keep;
      ST_POWER_DOWN: main_osc_off = 1'b1;
      default:       main_osc_off = 1'b0;
    endcase
  endfunction

  function automatic logic is_sleeping(sleep_state_t st);
    is_sleeping = (st == ST_IDLE) || (st == ST_STANDBY) ||
                  (st == ST_POWER_DOWN);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************

  sleep_state_t          state;
  sleep_state_t          next_state;
  logic [CONTROL_W-1:0]  control;
  logic [CONTROL_W-1:0]  next_control;
  logic [31:0]           next_prdata;
  logic                  next_cpu_clk_en;
  logic                  next_wake_resume;
  logic [N_PERIPH-1:0]   next_periph_clk_en;
  logic                  next_main_osc_en;
  logic                  next_ulp_osc_en;
  logic                  next_rtc_clk_en;
  logic                  hit_ctrl;
  logic                  hit_status;
  logic                  osc_keep;
  logic                  sby_wake;
  logic                  pd_wake;
  logic                  wake;
  logic [1:0]            mode;

  wake_timer_if tif();

  // ****************************************************************
  // Register bus
  // ****************************************************************

  assign hit_ctrl   = (PADDR == SLEEP_CONTROL_OFF);
  assign hit_status = (PADDR == SLEEP_STATUS_OFF);
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL && PENABLE && !hit_ctrl && !hit_status;

  always_comb
  begin
    next_control = control;
    next_prdata  = PRDATA;
    // Read data is caught in the setup cycle, so no wait state is needed.
    if (PSEL && !PENABLE)
    begin
      if (hit_ctrl)
      begin
        next_prdata = {29'h0000000, control};
      end
      else if (hit_status)
      begin
        next_prdata = {27'h0000000, state};
      end
      else
      begin
        next_prdata = 32'h00000000;
      end
    end
    if (PSEL && PENABLE && PWRITE && hit_ctrl)
    begin
      next_control = PWDATA[CONTROL_W-1:0];
    end
  end

  // The control value survives sleep; only a reset or a bus write changes it.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      control <= SLEEP_CONTROL_RST;
      PRDATA  <= 32'h00000000;
    end
    else
    begin
      control <= next_control;
      PRDATA  <= next_prdata;
    end
  end

  // ****************************************************************
  // Wake decoding
  // ****************************************************************

  assign mode     = control[MODE_MSB:MODE_LSB];
  assign osc_keep = MAIN_OSC_RUN_IN_STANDBY || (|PERIPH_RUN_IN_STANDBY) || (|SBY_RUN);
  assign sby_wake = WAKE_PIN || WAKE_PIT || WAKE_VLM || WAKE_TWI ||
                    (|(WAKE_SBY & SBY_RUN));
  assign pd_wake  = WAKE_PIN || WAKE_PIT || WAKE_VLM || WAKE_TWI ||
                    (WAKE_SBY[WK_CUSTOM] && CUSTOM_CLOCKLESS);

  always_comb
  begin
    wake = 1'b0;
    case (state)
      ST_IDLE:       wake = IRQ_ANY || sby_wake || (|WAKE_SBY);
      ST_STANDBY:    wake = sby_wake;
      ST_POWER_DOWN: wake = pd_wake;
      default:       wake = 1'b0;
    endcase
    // A debug break wakes any sleep mode, pending interrupt or not.
    if (is_sleeping(state) && DEBUG_BREAK)
    begin
      wake = 1'b1;
    end
  end

  // ****************************************************************
  // Wake timer
  // ****************************************************************

  assign tif.start     = is_sleeping(state) && wake;
  assign tif.need_osc  = main_osc_off(state, osc_keep);
  assign tif.need_bod  = (BOD_ACTIVE_CFG == BOD_WAIT_CFG);
  assign tif.osc_ready = OSC_READY;
  assign tif.bod_ready = BOD_READY;

  wake_timer #(
    .WAKE_CYCLES (WAKE_CLK_CYCLES),
    .CNT_W       (3)
  ) u_wake_timer (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .tif    (tif)
  );

  // ****************************************************************
  // Sleep state machine and clock gating
  // ****************************************************************

  // Debug has no effect on this machine apart from the break wake.
  always_comb
  begin
    next_state       = state;
    next_wake_resume = 1'b0;
    case (state)
      ST_ACTIVE:
      begin
        // The enable bit is sampled only at the sleep instruction.
        if (SLEEP_EXEC && control[SEN_BIT])
        begin
          case (mode)
            MODE_IDLE:       next_state = ST_IDLE;
            MODE_STANDBY:    next_state = ST_STANDBY;
            MODE_POWER_DOWN: next_state = ST_POWER_DOWN;
            default:         next_state = ST_ACTIVE;
          endcase
        end
      end
      ST_IDLE, ST_STANDBY, ST_POWER_DOWN:
      begin
        if (wake)
        begin
          next_state = ST_WAKING;
        end
      end
      ST_WAKING:
      begin
        if (tif.done)
        begin
          next_state       = ST_ACTIVE;
          // The CPU takes its interrupt, then resumes after the sleep.
          next_wake_resume = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  // Gates follow the next state so that they change with the state.
  always_comb
  begin
    next_cpu_clk_en    = (next_state == ST_ACTIVE);
    next_periph_clk_en = {N_PERIPH{1'b1}};
    next_main_osc_en   = !main_osc_off(next_state, osc_keep);
    next_ulp_osc_en    = 1'b1;
    next_rtc_clk_en    = 1'b1;
    case (next_state)
      ST_STANDBY:
      begin
        next_periph_clk_en = PERIPH_RUN_IN_STANDBY;
        next_rtc_clk_en    = SBY_RUN[WK_RTC] || RTC_CLK_REQ;
      end
      ST_POWER_DOWN:
      begin
        next_periph_clk_en = {N_PERIPH{1'b0}};
        next_ulp_osc_en    = ULP_REQ;
        next_rtc_clk_en    = RTC_CLK_REQ;
      end
      default:
      begin
        next_periph_clk_en = {N_PERIPH{1'b1}};
      end
    endcase
  end

  // A reset in any sleep mode lands straight in the active state.
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state         <= ST_ACTIVE;
      CPU_CLK_EN    <= 1'b1;
      WAKE_RESUME   <= 1'b0;
      PERIPH_CLK_EN <= {N_PERIPH{1'b1}};
      MAIN_OSC_EN   <= 1'b1;
      ULP_OSC_EN    <= 1'b1;
      RTC_CLK_EN    <= 1'b1;
    end
    else
    begin
      state         <= next_state;
      CPU_CLK_EN    <= next_cpu_clk_en;
      WAKE_RESUME   <= next_wake_resume;
      PERIPH_CLK_EN <= next_periph_clk_en;
      MAIN_OSC_EN   <= next_main_osc_en;
      ULP_OSC_EN    <= next_ulp_osc_en;
      RTC_CLK_EN    <= next_rtc_clk_en;
    end
  end

endmodule

`default_nettype wire

/* sleep_controller_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module sleep_controller_monitor
  import sleep_pkg::*;
#(
  parameter int N_PERIPH = 8
)
(
  // Clock, reset and bus.
  input wire logic                  CORE_CLK,
  input wire logic                  ARST_N,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [APB_ADDR_W-1:0] PADDR,
  input wire logic [31:0]           PWDATA,
  input wire logic [31:0]           PRDATA,
  // CPU side and wake sources.
  input wire logic                  SLEEP_EXEC,
  input wire logic                  IRQ_ANY,
  input wire logic                  DEBUG_BREAK,
  input wire logic                  CPU_CLK_EN,
  input wire logic                  WAKE_RESUME,
  input wire logic                  WAKE_PIN,
  input wire logic                  WAKE_PIT,
  input wire logic                  WAKE_VLM,
  input wire logic                  WAKE_TWI,
  input wire logic [N_SBY_WAKE-1:0] WAKE_SBY,
  input wire logic [N_SBY_WAKE-1:0] SBY_RUN,
  input wire logic                  CUSTOM_CLOCKLESS,
  // Gating and brown-out.
  input wire logic [N_PERIPH-1:0]   PERIPH_RUN_IN_STANDBY,
  input wire logic [N_PERIPH-1:0]   PERIPH_CLK_EN,
  input wire logic                  MAIN_OSC_EN,
  input wire logic [1:0]            BOD_ACTIVE_CFG,
  input wire logic                  BOD_READY
);
  // ********************
  // Shadow state.
  // ********************
  // The shadow tracks the mode from bus writes and the sleep instruction, so the wake decode
  // below is an independent model and not a copy of the design.
  logic [2:0] ctl;
  logic [2:0] next_ctl;
  logic [1:0] md;
  logic [1:0] next_md;
  logic       slp;
  logic       next_slp;
  logic       ent;
  logic       wk;
  logic       bus;

  always_comb
  begin
    bus = PSEL && PENABLE && PADDR == SLEEP_CONTROL_OFF;
    ent = SLEEP_EXEC && CPU_CLK_EN && ctl[SEN_BIT] && ctl[2:1] != 2'h3;
    wk = WAKE_PIN || WAKE_PIT || WAKE_VLM || WAKE_TWI || DEBUG_BREAK;
    if (md == MODE_IDLE)
      wk = wk || IRQ_ANY || (|WAKE_SBY);
    else if (md == MODE_STANDBY)
      wk = wk || (|(WAKE_SBY & SBY_RUN));
    else
      wk = wk || (WAKE_SBY[WK_CUSTOM] && CUSTOM_CLOCKLESS);
    next_ctl = (bus && PWRITE) ? PWDATA[2:0] : ctl;
    next_md = ent ? ctl[2:1] : md;
    next_slp = ent || (slp && !wk);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctl <= SLEEP_CONTROL_RST;
      md  <= MODE_IDLE;
      slp <= 1'b0;
    end
    else
    begin
      ctl <= next_ctl;
      md  <= next_md;
      slp <= next_slp;
    end
  end

  // ********************
  // Properties.
  // ********************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_waking;
    !CPU_CLK_EN [*6];
  endsequence
  sequence s_resume;
    CPU_CLK_EN && WAKE_RESUME;
  endsequence

  a_ctl_read: assert property (bus && !PWRITE |-> PRDATA == {29'h0, ctl})
    else $error("control read mismatch");
  a_enter_sleep: assert property (ent |=> !CPU_CLK_EN)
    else $error("sleep not entered");
  a_skip_sleep: assert property (SLEEP_EXEC && CPU_CLK_EN && !ent
    |=> CPU_CLK_EN) else $error("sleep entered wrongly");
  a_idle_clocks: assert property (slp && md == MODE_IDLE
    |-> &PERIPH_CLK_EN && MAIN_OSC_EN && !CPU_CLK_EN)
    else $error("idle gating wrong");
  a_stby_gate: assert property (slp && md == MODE_STANDBY
    |-> PERIPH_CLK_EN == PERIPH_RUN_IN_STANDBY) else $error("standby gating wrong");
  a_power_down_mode_gate: assert property (slp && md == MODE_POWER_DOWN
    |-> PERIPH_CLK_EN == '0 && !MAIN_OSC_EN && !CPU_CLK_EN)
    else $error("power-down gating wrong");
  a_wake_restore: assert property (slp && wk
    |=> &PERIPH_CLK_EN && MAIN_OSC_EN && !CPU_CLK_EN)
    else $error("wake did not restore clocks");
  a_idle_wake: assert property (slp && wk && md == MODE_IDLE
    |=> s_waking ##1 s_resume) else $error("idle wake time wrong");
  a_deep_wake: assert property (slp && wk && md != MODE_IDLE
    |=> s_waking ##[1:100] s_resume) else $error("deep wake time wrong");
  a_bod_hold: assert property (BOD_ACTIVE_CFG == BOD_WAIT_CFG
    && !BOD_READY && !CPU_CLK_EN |=> !CPU_CLK_EN)
    else $error("resumed before brown-out ready");
  a_resume_once: assert property ($rose(CPU_CLK_EN)
    |-> WAKE_RESUME ##1 !WAKE_RESUME) else $error("resume pulse wrong");
endmodule

bind sleep_controller sleep_controller_monitor #(.N_PERIPH(N_PERIPH)) i_mon
(
  .CORE_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .SLEEP_EXEC, .IRQ_ANY, .DEBUG_BREAK, .CPU_CLK_EN, .WAKE_RESUME,
  .WAKE_PIN, .WAKE_PIT, .WAKE_VLM, .WAKE_TWI, .WAKE_SBY, .SBY_RUN,
  .CUSTOM_CLOCKLESS, .PERIPH_RUN_IN_STANDBY, .PERIPH_CLK_EN, .MAIN_OSC_EN,
  .BOD_ACTIVE_CFG, .BOD_READY
);

`default_nettype wire

/* core_model.sv */
`timescale 1ns/10ps
`default_nettype none

module core_model
#(
  parameter int OSC_START = 10
)
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic arst_n,
  // Controller side.
  input  wire logic cpu_clk_en,
  input  wire logic main_osc_en,
  output var  logic sleep_exec,
  output var  logic osc_ready
);
  int   cnt;
  int   next_cnt;
  logic next_rdy;

  initial sleep_exec = 1'b0;

  // The instruction only issues while the CPU clock runs.
  task automatic run_sleep();
    while (cpu_clk_en !== 1'b1)
      @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
  endtask

  // Output is lost at once on disable and a start-up wait follows each
  // enable, so a wake from a stopped oscillator can never be quick.
  always_comb
  begin
    next_cnt = main_osc_en ? cnt + ((cnt < OSC_START) ? 1 : 0) : 0;
    next_rdy = main_osc_en && cnt >= OSC_START;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt       <= 0;
      osc_ready <= 1'b0;
    end
    else
    begin
      cnt       <= next_cnt;
      osc_ready <= next_rdy;
    end
  end
endmodule

`default_nettype wire

/* sleep_controller_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module sleep_controller_tb
  import sleep_pkg::*;
  ;
  localparam int OSC_ST = 10;
  logic                  CORE_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY;
  logic                  PSLVERR, SLEEP_EXEC, IRQ_ANY, DEBUG_BREAK, err;
  logic                  CPU_CLK_EN, WAKE_RESUME, WAKE_PIN, WAKE_PIT;
  logic                  WAKE_VLM, WAKE_TWI, CUSTOM_CLOCKLESS, OSC_READY;
  logic                  MAIN_OSC_RUN_IN_STANDBY, ULP_REQ, RTC_CLK_REQ, BOD_READY;
  logic                  MAIN_OSC_EN, ULP_OSC_EN, RTC_CLK_EN;
  logic [APB_ADDR_W-1:0] PADDR;
  logic [31:0]           PWDATA, PRDATA, q;
  logic [N_SBY_WAKE-1:0] WAKE_SBY, SBY_RUN;
  logic [7:0]            PERIPH_RUN_IN_STANDBY, PERIPH_CLK_EN;
  logic [1:0]            BOD_ACTIVE_CFG;
  int                    miscompares, tests_run, cyc, n;

  sleep_controller #(.N_PERIPH(8)) i_dut
  (
    .CORE_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .SLEEP_EXEC, .IRQ_ANY, .DEBUG_BREAK, .CPU_CLK_EN,
    .WAKE_RESUME, .WAKE_PIN, .WAKE_PIT, .WAKE_VLM, .WAKE_TWI, .WAKE_SBY,
    .SBY_RUN, .CUSTOM_CLOCKLESS, .PERIPH_RUN_IN_STANDBY, .PERIPH_CLK_EN,
    .MAIN_OSC_RUN_IN_STANDBY, .OSC_READY, .ULP_REQ, .RTC_CLK_REQ, .BOD_ACTIVE_CFG,
    .BOD_READY, .MAIN_OSC_EN, .ULP_OSC_EN, .RTC_CLK_EN
  );

  core_model #(.OSC_START(OSC_ST)) i_cpu
  (
    .clk(CORE_CLK), .arst_n(ARST_N), .cpu_clk_en(CPU_CLK_EN),
    .main_osc_en(MAIN_OSC_EN), .sleep_exec(SLEEP_EXEC), .osc_ready(OSC_READY)
  );

  // ********************
  // Tasks.
  // ********************
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Every task starts and ends just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1)
      @(posedge CORE_CLK);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic slp(input logic [1:0] m);
    apb(1'b1, SLEEP_CONTROL_OFF, {29'h0, m, 1'b1});
    i_cpu.run_sleep();
    repeat (2) @(posedge CORE_CLK);
  endtask

  // Counts edges up to the one that samples the resume pulse.
  task automatic wait_resume();
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (WAKE_RESUME !== 1'b1);
  endtask

  // ********************
  // Stimulus.
  // ********************
  initial
  begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      conclude();
    end
  end

  initial
  begin
    {ARST_N, PSEL, PENABLE, PWRITE, IRQ_ANY, DEBUG_BREAK, WAKE_PIN} = 7'h0;
    {WAKE_PIT, WAKE_VLM, WAKE_TWI, CUSTOM_CLOCKLESS, MAIN_OSC_RUN_IN_STANDBY} = 5'h0;
    {ULP_REQ, RTC_CLK_REQ, PADDR, PWDATA, BOD_ACTIVE_CFG} = 44'h0;
    {WAKE_SBY, SBY_RUN, PERIPH_RUN_IN_STANDBY} = 20'h0;
    BOD_READY = 1'b1;
    repeat (20) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    rd(SLEEP_CONTROL_OFF, 32'h0);
    rd(SLEEP_STATUS_OFF, 32'h1);
    apb(1'b1, SLEEP_CONTROL_OFF, 32'hffff_ffff);
    rd(SLEEP_CONTROL_OFF, 32'h7);
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, err}, 32'h1);
    i_cpu.run_sleep();
    rd(SLEEP_STATUS_OFF, 32'h1);
    apb(1'b1, SLEEP_CONTROL_OFF, 32'h2);
    i_cpu.run_sleep();
    rd(SLEEP_STATUS_OFF, 32'h1);
    slp(MODE_IDLE);
    rd(SLEEP_STATUS_OFF, 32'h2);
    chk(32'(PERIPH_CLK_EN), 32'hff);
    IRQ_ANY <= 1'b1;
    wait_resume();
    chk(32'(n), 32'(WAKE_CLK_CYCLES + 2));
    IRQ_ANY <= 1'b0;
    rd(SLEEP_CONTROL_OFF, 32'h1);
    PERIPH_RUN_IN_STANDBY <= 8'h0f;
    WAKE_SBY <= 6'h3f;
    slp(MODE_STANDBY);
    repeat (10) @(posedge CORE_CLK);
    rd(SLEEP_STATUS_OFF, 32'h4);
    chk(32'({PERIPH_CLK_EN, MAIN_OSC_EN}), 32'h1f);
    SBY_RUN <= 6'h08;
    wait_resume();
    chk(32'(n), 32'(WAKE_CLK_CYCLES + 2));
    {WAKE_SBY, SBY_RUN, PERIPH_RUN_IN_STANDBY} <= 20'h0;
    {ULP_REQ, RTC_CLK_REQ, BOD_ACTIVE_CFG, BOD_READY, IRQ_ANY} <= 6'h3d;
    WAKE_SBY <= 6'h3f;
    slp(MODE_POWER_DOWN);
    repeat (10) @(posedge CORE_CLK);
    rd(SLEEP_STATUS_OFF, 32'h8);
    chk(32'({PERIPH_CLK_EN, MAIN_OSC_EN, ULP_OSC_EN, RTC_CLK_EN}), 32'h3);
    DEBUG_BREAK <= 1'b1;
    repeat (40) @(posedge CORE_CLK);
    rd(SLEEP_STATUS_OFF, 32'h10);
    {DEBUG_BREAK, BOD_READY} <= 2'h1;
    wait_resume();
    chk(32'(n <= WAKE_CLK_CYCLES + 2), 32'h1);
    {IRQ_ANY, BOD_ACTIVE_CFG} <= 3'h0;
    WAKE_SBY <= 6'h02;
    slp(MODE_POWER_DOWN);
    CUSTOM_CLOCKLESS <= 1'b1;
    wait_resume();
    chk(32'(n > OSC_ST + WAKE_CLK_CYCLES), 32'h1);
    CUSTOM_CLOCKLESS <= 1'b0;
    WAKE_SBY <= 6'h00;
    slp(MODE_STANDBY);
    chk(32'(MAIN_OSC_EN), 32'h0);
    ARST_N <= 1'b0;
    @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    rd(SLEEP_STATUS_OFF, 32'h1);
    chk(32'(CPU_CLK_EN), 32'h1);
    conclude();
  end
endmodule

`default_nettype wire
